// ==== core/coc_pkg.sv ====
package coc_pkg;

    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int NCH = 8;
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // reset values of the configuration
    // ------------------------------------------------------------
    localparam logic [15:0] TIMEOUT_MS_RST = 16'h01F4;
    localparam logic [1:0] RANGE_RST = 2'h1;
    localparam logic [2:0] DIAG_BYTES_RST = 3'h4;
    localparam logic [7:0] ACTIVE_RST = 8'hFF;

    // ------------------------------------------------------------
    // range selections
    // ------------------------------------------------------------
    localparam logic [1:0] RANGE_CUSTOM = 2'h0;
    localparam logic [1:0] RANGE_4_20 = 2'h1;
    localparam logic [1:0] RANGE_0K_4_20 = 2'h2;
    localparam logic [1:0] RANGE_0K_0_20 = 2'h3;
    localparam logic [15:0] ENG_4000 = 16'h0FA0;
    localparam logic [15:0] ENG_20000 = 16'h4E20;
    localparam logic [15:0] ENG_ZERO = 16'h0000;
    localparam logic [15:0] ENG_32000 = 16'h7D00;
    localparam logic [15:0] SPAN_4000 = 16'h0FA0;
    localparam logic [15:0] SPAN_20000 = 16'h4E20;
    localparam logic [15:0] SPAN_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // output code: 0.3125 uA a count, i.e. 16 counts per 5 uA
    // ------------------------------------------------------------
    localparam int UA_CNT_MUL = 16;
    localparam int UA_CNT_DIV = 5;
    localparam logic [15:0] CODE_MAX = 16'hFFFF;
    localparam logic [15:0] HOLD_MASK = 16'hFFFC;
    localparam int OPEN_WIRE_UA = 2000;
    localparam logic [15:0] OPEN_WIRE_CNT = 16'(OPEN_WIRE_UA * UA_CNT_MUL / UA_CNT_DIV);

    // ------------------------------------------------------------
    // diagnostic and clearing bit positions
    // ------------------------------------------------------------
    localparam int DIAG_TIMEOUT = 3;
    localparam int DIAG_USER = 7;
    localparam logic [7:0] DIAG_CAL_MASK = 8'h57;
    localparam int DIAG_RANGE_BASE = 8;
    localparam int DIAG_OPEN_BASE = 24;
    localparam int CLR_USER = 8;
    localparam int CLR_TIMEOUT = 9;

    typedef struct packed {
        logic signed [15:0] engLo;
        logic signed [15:0] engHi;
        logic [15:0] spanLo;
        logic [15:0] spanHi;
    } coc_points_type;

    localparam coc_points_type POINTS_RST = '{ENG_4000, ENG_20000, SPAN_4000, SPAN_20000};

endpackage

// ==== core/coc_if.sv ====
`timescale 1ns/1ps
interface coc_if;
    // output table and fault clearing, from the bus interface unit
    logic cmdValid;
    logic [coc_pkg::NCH-1:0][15:0] cmdData;
    logic clrValid;
    logic [15:0] clrData;
    logic modReset;
    logic scanEnable;
    // configuration
    logic [coc_pkg::NCH-1:0] cfgActive;
    logic cfgHoldLast;
    logic [15:0] cfgTimeoutMs;
    logic [2:0] cfgDiagBytes;
    logic [coc_pkg::NCH-1:0][1:0] cfgRange;
    coc_pkg::coc_points_type [coc_pkg::NCH-1:0] cfgPoints;
    // diagnostic input table
    logic [31:0] diag;

    modport device (
        input cmdValid, cmdData, clrValid, clrData, modReset, scanEnable,
        input cfgActive, cfgHoldLast, cfgTimeoutMs, cfgDiagBytes, cfgRange, cfgPoints,
        output diag
    );
    modport host (
        output cmdValid, cmdData, clrValid, clrData, modReset, scanEnable,
        output cfgActive, cfgHoldLast, cfgTimeoutMs, cfgDiagBytes, cfgRange, cfgPoints,
        input diag
    );
endinterface

// ==== core/coc_scaler.sv ====
`timescale 1ns/1ps
module coc_scaler (
    // command and scaling points
    input wire logic signed [15:0] cmd,
    input coc_pkg::coc_points_type pts,
    // scaled code and clamp flags
    output logic [15:0] code,
    output logic under,
    output logic over
);
    logic signed [47:0] eDiff;
    logic signed [47:0] sDiff;
    logic signed [47:0] cDiff;
    logic signed [47:0] sLo;
    logic signed [47:0] num;
    logic signed [47:0] den;
    logic signed [47:0] q;

    // interpolate in counts, round to nearest, then clamp
    always_comb
    begin
        eDiff = 48'(pts.engHi) - 48'(pts.engLo);
        sLo = $signed({32'h0000_0000, pts.spanLo});
        sDiff = $signed({32'h0000_0000, pts.spanHi}) - sLo;
        cDiff = 48'(cmd) - 48'(pts.engLo);
        num = (cDiff * sDiff + sLo * eDiff) * 48'(coc_pkg::UA_CNT_MUL);
        den = eDiff * 48'(coc_pkg::UA_CNT_DIV);
        if (eDiff == 48'sh0)
        begin
            // degenerate points: fall back to the low span
            num = sLo * 48'(coc_pkg::UA_CNT_MUL);
            den = 48'(coc_pkg::UA_CNT_DIV);
        end
        else if (den < 48'sh0)
        begin
            num = -num;
            den = -den;
        end
        if (num >= 48'sh0)
            q = (num + (den >>> 1)) / den;
        else
            q = -(((den >>> 1) - num) / den);
        under = (q < 48'sh0);
        over = (q > $signed({32'h0000_0000, coc_pkg::CODE_MAX}));
        if (under)
            code = 16'h0000;
        else if (over)
            code = coc_pkg::CODE_MAX;
        else
            code = q[15:0];
    end

endmodule // coc_scaler

// ==== core/coc_device.sv ====
`timescale 1ns/1ps
// Operation
// - inactive channel outputs zero, ignores command
// - inactive channel alarms are not updated
// - deactivated channel alarms still clearable
// - local default selects zero or hold
// - hold on reset, timeout, backplane loss, watchdog
// - backplane or watchdog hold keeps 14 bits
// - hold lasts until new data or power
// - three preset ranges plus custom points
// - linear map between engineering and span points
// - span unsigned uA, engineering 16-bit signed
// - no clamp at points, extrapolate slope
// - clamp current to zero..overrange ceiling
// - code weight 0.3125 uA per count
// - open wire alarm at or above current threshold
// - 32 diagnostic bits to input table
// - diagnostic bits sticky until cleared, re-set
// - calibration bits not clearable
// - byte 1 holds range pairs channels 1-4
// - bus unit sends two clearing bytes
// - first clearing byte clears channel alarms
// - second byte clears supply and timeout
// - output timeout applies local defaults
// - diagnostic length configurable in bytes
module coc_device #(
    parameter int NCH = coc_pkg::NCH,
    parameter int MS_CYCLES = coc_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // bus interface unit side
    coc_if.device bus,
    // analog and supervision pins
    input wire logic userPowerOk,
    input wire logic backplaneLost,
    input wire logic watchdogExpired,
    input wire logic [NCH-1:0] openWireSense,
    input wire logic [4:0] calFault,
    // current codes to the converters
    output logic [NCH-1:0][15:0] dacCode
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int PIN_W = NCH + 8;
    logic [PIN_W-1:0] pinMeta_q, pinSync_q;
    logic userOk, bpLost, wdExp, bpLost_q, wdExp_q;
    logic [4:0] calSync;
    logic msTick, toDone_q, toEvt, holdEvt, reducedEvt;
    logic [15:0] toCnt_q;
    logic [NCH-1:0][15:0] scaled;
    logic [NCH-1:0] owSync, scUnder, scOver, under_q, over_q;
    logic [31:0] msCnt_q, setV, clrV, diag_q, diagOut_q;

    // reported diagnostic bytes, zeros above the configured length
    function automatic logic [31:0] diagMask(input logic [2:0] nBytes);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            if (nBytes > 3'(i))
                m[8*i +: 8] = 8'hFF;
        end
        return m;
    endfunction

    // scaling points for the selected range
    function automatic coc_pkg::coc_points_type pickPoints(
        input logic [1:0] sel,
        input coc_pkg::coc_points_type custom
    );
        coc_pkg::coc_points_type p;
        case (sel)
            coc_pkg::RANGE_4_20:
                p = '{coc_pkg::ENG_4000, coc_pkg::ENG_20000, coc_pkg::SPAN_4000,
                    coc_pkg::SPAN_20000};
            coc_pkg::RANGE_0K_4_20:
                p = '{coc_pkg::ENG_ZERO, coc_pkg::ENG_32000, coc_pkg::SPAN_4000,
                    coc_pkg::SPAN_20000};
            coc_pkg::RANGE_0K_0_20:
                p = '{coc_pkg::ENG_ZERO, coc_pkg::ENG_32000, coc_pkg::SPAN_ZERO,
                    coc_pkg::SPAN_20000};
            default:
                p = custom;
        endcase
        return p;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // two stages for every asynchronous pin
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end
        else
        begin
            pinMeta_q <= {calFault, watchdogExpired, backplaneLost, userPowerOk, openWireSense};
            pinSync_q <= pinMeta_q;
        end
    end

    assign owSync = pinSync_q[NCH-1:0];
    assign userOk = pinSync_q[NCH];
    assign bpLost = pinSync_q[NCH+1];
    assign wdExp = pinSync_q[NCH+2];
    assign calSync = pinSync_q[NCH+7:NCH+3];

    // edge history for the backplane and watchdog inputs
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            {bpLost_q, wdExp_q} <= 2'h0;
        else
            {bpLost_q, wdExp_q} <= {bpLost, wdExp};
    end

    // ------------------------------------------------------------
    // output data timeout
    // ------------------------------------------------------------
    // millisecond enable pulse
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            msCnt_q <= 32'h0000_0000;
        else if (msTick || bus.cmdValid)
            msCnt_q <= 32'h0000_0000;
        else
            msCnt_q <= msCnt_q + 32'h0000_0001;
    end

    assign msTick = (msCnt_q == 32'(MS_CYCLES - 1));

    // zero timeout disables it; fires once per silent stretch
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            {toCnt_q, toDone_q} <= '0;
        else if (bus.cmdValid || !bus.scanEnable)
            {toCnt_q, toDone_q} <= '0;
        else if (toEvt)
            toDone_q <= 1'b1;
        else if (msTick && !toDone_q)
            toCnt_q <= toCnt_q + 16'h0001;
    end

    assign toEvt = !toDone_q && (bus.cfgTimeoutMs != 16'h0000)
        && (toCnt_q >= bus.cfgTimeoutMs);

    // ------------------------------------------------------------
    // scaling and output codes
    // ------------------------------------------------------------
    generate
        for (genvar c = 0; c < NCH; c++)
        begin : gScale
            coc_scaler uScale (
                .cmd($signed(bus.cmdData[c])),
                .pts(pickPoints(bus.cfgRange[c], bus.cfgPoints[c])),
                .code(scaled[c]),
                .under(scUnder[c]),
                .over(scOver[c])
            );
        end
    endgenerate

    assign reducedEvt = (bpLost && !bpLost_q) || (wdExp && !wdExp_q);
    assign holdEvt = bus.modReset || toEvt || reducedEvt;

    // fresh data first, then loss of user power, then faults
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            dacCode <= '0;
        else
        begin
            if (bus.cmdValid)
                dacCode <= scaled;
            else if (!userOk)
                dacCode <= '0;
            else if (holdEvt)
                for (int c = 0; c < NCH; c++)
                begin
                    if (!bus.cfgHoldLast)
                        dacCode[c] <= 16'h0000;
                    else if (reducedEvt)
                        dacCode[c] <= dacCode[c] & coc_pkg::HOLD_MASK;
                end
            // inactive channel sits at zero whatever was commanded
            for (int c = 0; c < NCH; c++)
            begin
                if (!bus.cfgActive[c])
                    dacCode[c] <= 16'h0000;
            end
        end
    end

    // clamp conditions of the last accepted command
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            {under_q, over_q} <= '0;
        else if (bus.cmdValid)
            {under_q, over_q} <= {scUnder, scOver};
    end

    // ------------------------------------------------------------
    // diagnostics
    // ------------------------------------------------------------
    // set and clear vectors; clears reach inactive channels too
    always_comb
    begin
        setV = 32'h0000_0000;
        clrV = 32'h0000_0000;
        setV[7:0] = {1'b0, calSync[4], 1'b0, calSync[3], 1'b0, calSync[2:0]}
            & coc_pkg::DIAG_CAL_MASK;
        setV[coc_pkg::DIAG_USER] = !userOk;
        setV[coc_pkg::DIAG_TIMEOUT] = toEvt;
        for (int c = 0; c < NCH; c++)
        begin
            if (bus.cfgActive[c])
            begin
                setV[coc_pkg::DIAG_RANGE_BASE + 2*c] = under_q[c];
                setV[coc_pkg::DIAG_RANGE_BASE + 2*c + 1] = over_q[c];
                setV[coc_pkg::DIAG_OPEN_BASE + c] = owSync[c]
                    && (dacCode[c] >= coc_pkg::OPEN_WIRE_CNT);
            end
            if (bus.clrValid && bus.clrData[c])
            begin
                clrV[coc_pkg::DIAG_RANGE_BASE + 2*c] = 1'b1;
                clrV[coc_pkg::DIAG_RANGE_BASE + 2*c + 1] = 1'b1;
                clrV[coc_pkg::DIAG_OPEN_BASE + c] = 1'b1;
            end
        end
        if (bus.clrValid)
        begin
            clrV[coc_pkg::DIAG_USER] = bus.clrData[coc_pkg::CLR_USER];
            clrV[coc_pkg::DIAG_TIMEOUT] = bus.clrData[coc_pkg::CLR_TIMEOUT];
        end
        clrV[7:0] = clrV[7:0] & ~coc_pkg::DIAG_CAL_MASK;
    end

    // sticky bits; a set in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            diag_q <= 32'h0000_0000;
        else
            diag_q <= (diag_q & ~clrV) | setV;
    end

    // reported table trimmed to the configured byte count
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            diagOut_q <= 32'h0000_0000;
        else
            diagOut_q <= diag_q & diagMask(bus.cfgDiagBytes);
    end

    assign bus.diag = diagOut_q;

endmodule // coc_device

// ==== core/coc_host.sv ====
`timescale 1ns/1ps
module coc_host #(
    parameter int NCH = coc_pkg::NCH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // link to the output module
    coc_if.host bus,
    // output table requests
    input wire logic cmdReq,
    input wire logic [NCH-1:0][15:0] cmdWords,
    input wire logic clrReq,
    input wire logic [15:0] clrWord,
    input wire logic resetReq,
    input wire logic scanEnable,
    // configuration load
    input wire logic cfgLoad,
    input wire logic [NCH-1:0] cfgActive,
    input wire logic cfgHoldLast,
    input wire logic [15:0] cfgTimeoutMs,
    input wire logic [2:0] cfgDiagBytes,
    input wire logic [NCH-1:0][1:0] cfgRange,
    input coc_pkg::coc_points_type [NCH-1:0] cfgPoints,
    // captured diagnostic table
    output logic [31:0] diagWord
);
    // ------------------------------------------------------------
    // request strobes and data
    // ------------------------------------------------------------
    // strobes follow the requests one cycle later, data registered with them
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus.cmdValid <= 1'b0;
            bus.cmdData <= '0;
            bus.clrValid <= 1'b0;
            bus.clrData <= 16'h0000;
            bus.modReset <= 1'b0;
            bus.scanEnable <= 1'b0;
        end
        else
        begin
            bus.cmdValid <= cmdReq;
            bus.clrValid <= clrReq;
            bus.modReset <= resetReq;
            bus.scanEnable <= scanEnable;
            if (cmdReq)
                bus.cmdData <= cmdWords;
            if (clrReq)
                bus.clrData <= clrWord;
        end
    end

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    // held until the next load so the module never sees it change mid-use
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus.cfgActive <= coc_pkg::ACTIVE_RST;
            bus.cfgHoldLast <= 1'b0;
            bus.cfgTimeoutMs <= coc_pkg::TIMEOUT_MS_RST;
            bus.cfgDiagBytes <= coc_pkg::DIAG_BYTES_RST;
            bus.cfgRange <= {NCH{coc_pkg::RANGE_RST}};
            bus.cfgPoints <= {NCH{coc_pkg::POINTS_RST}};
        end
        else if (cfgLoad)
        begin
            bus.cfgActive <= cfgActive;
            bus.cfgHoldLast <= cfgHoldLast;
            bus.cfgTimeoutMs <= cfgTimeoutMs;
            bus.cfgDiagBytes <= cfgDiagBytes;
            bus.cfgRange <= cfgRange;
            bus.cfgPoints <= cfgPoints;
        end
    end

    // diagnostic table sampled every cycle
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            diagWord <= 32'h0000_0000;
        else
            diagWord <= bus.diag;
    end

endmodule // coc_host

// ==== dv/coc_chk.sv ====
`timescale 1ns/1ps
module coc_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // link signals under watch
    input wire logic cmdValid,
    input wire logic clrValid,
    input wire logic [15:0] clrData,
    input wire logic [coc_pkg::NCH-1:0] cfgActive,
    input wire logic [2:0] cfgDiagBytes,
    input wire logic [31:0] diag
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // sticky bits fall only after a clear
    // ----------------------------------------
    // full length held, so masking cannot explain a drop
    sequence fullLen;
        (cfgDiagBytes == 3'h4) [*3];
    endsequence

    cal_sticky_a: assert property (
        fullLen |-> ($past(diag[7:0]) & ~diag[7:0] & 8'h57) == 8'h00)
        else $error("calibration bit dropped");
    range_clear_a: assert property (
        fullLen ##0 $fell(diag[8]) |-> $past(clrValid, 2) && $past(clrData[0], 2))
        else $error("channel alarm fell without a clear");
    timeout_clear_a: assert property (
        fullLen ##0 $fell(diag[3]) |-> $past(clrValid, 2) && $past(clrData[9], 2))
        else $error("timeout flag fell without a clear");
    user_clear_a: assert property (
        fullLen ##0 $fell(diag[7]) |-> $past(clrValid, 2) && $past(clrData[8], 2))
        else $error("supply flag fell without a clear");

    // ----------------------------------------
    // inactive channels and report length
    // ----------------------------------------
    range_active_a: assert property (
        fullLen ##0 $rose(diag[9]) |-> $past(cfgActive[0], 2))
        else $error("alarm raised on an inactive channel");
    open_active_a: assert property (
        fullLen ##0 $rose(diag[24]) |-> $past(cfgActive[0], 2))
        else $error("open wire raised on an inactive channel");
    diag_len_a: assert property (
        (cfgDiagBytes == 3'h2) [*3] |-> diag[31:16] == 16'h0000)
        else $error("bytes beyond length reported");
    diag_off_a: assert property (
        (cfgDiagBytes == 3'h0) [*3] |-> diag == 32'h00000000)
        else $error("data reported with zero length");

    cover property (cmdValid && cfgActive != 8'hFF);
    cover property (clrValid && clrData[9]);
    cover property ($rose(diag[24]));
endmodule // coc_chk

// ==== dv/current_output_channel_control_bench.sv ====
`timescale 1ns/1ps
module current_output_channel_control_bench;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic sys_clk, resetn, cmdReq, clrReq, resetReq, scanEnable, cfgLoad, cfgHoldLast;
    logic userPowerOk, backplaneLost, watchdogExpired;
    logic [7:0][15:0] cmdWords, dacCode;
    logic [15:0] clrWord, cfgTimeoutMs, lfsr;
    logic [7:0] cfgActive, openWireSense;
    logic [7:0][1:0] cfgRange;
    logic [2:0] cfgDiagBytes;
    logic [4:0] calFault;
    logic [31:0] diagWord;
    coc_pkg::coc_points_type [7:0] cfgPoints;
    int errCount, cmpCount;
    localparam logic [15:0] CORNER [6] = '{16'h8000, 16'h7FFF, 16'h0000, 16'h0FA0, 16'h4E20,
        16'h7D00};

    coc_if link ();
    coc_host coc_host_i (.sys_clk, .resetn, .bus(link), .cmdReq, .cmdWords, .clrReq, .clrWord,
        .resetReq, .scanEnable, .cfgLoad, .cfgActive, .cfgHoldLast, .cfgTimeoutMs,
        .cfgDiagBytes, .cfgRange, .cfgPoints, .diagWord);
    // short millisecond so the timeout fits the run
    coc_device #(.MS_CYCLES(10)) coc_device_i (.sys_clk, .resetn, .bus(link), .userPowerOk,
        .backplaneLost, .watchdogExpired, .openWireSense, .calFault, .dacCode);
    coc_chk coc_chk_i (.sys_clk, .resetn, .cmdValid(link.cmdValid), .clrValid(link.clrValid),
        .clrData(link.clrData), .cfgActive(link.cfgActive), .cfgDiagBytes(link.cfgDiagBytes),
        .diag(link.diag));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // helpers and expectations
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmpCount++;
        if (seen !== want)
        begin
            errCount++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic giveVerdict();
        if (errCount == 0 && cmpCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hold a request n cycles, then leave room for syncs and pipeline
    task automatic pulse(ref logic req, input int n);
        req = 1'b1;
        tick(n);
        req = 1'b0;
        tick(8);
    endtask

    task automatic clear(input logic [15:0] w);
        clrWord = w;
        pulse(clrReq, 1);
    endtask

    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // unclamped code, exact rational rounded half away from zero
    function automatic longint rawOf(input int c);
        coc_pkg::coc_points_type p;
        longint de, num;
        p = (cfgRange[c] == 2'h0) ? cfgPoints[c] : coc_pkg::POINTS_RST;
        if (cfgRange[c][1])
        begin
            p.engLo = coc_pkg::ENG_ZERO;
            p.engHi = coc_pkg::ENG_32000;
        end
        if (cfgRange[c] == 2'h3)
            p.spanLo = coc_pkg::SPAN_ZERO;
        de = longint'(p.engHi) - longint'(p.engLo);
        num = 16 * (longint'(p.spanLo) * de + (longint'($signed(cmdWords[c]))
            - longint'(p.engLo)) * (longint'(p.spanHi) - longint'(p.spanLo)));
        if (de < 0)
        begin
            num = -num;
            de = -de;
        end
        de = 5 * de;
        return (num >= 0) ? (2 * num + de) / (2 * de) : -((de - 2 * num) / (2 * de));
    endfunction

    function automatic logic [15:0] expCode(input int c);
        longint r;
        r = rawOf(c);
        if (!cfgActive[c] || r < 0)
            return 16'h0000;
        return (r > 65535) ? 16'hFFFF : 16'(r);
    endfunction

    function automatic logic [15:0] rangeBits();
        logic [15:0] b;
        for (int c = 0; c < 8; c++)
        begin
            b[2*c] = cfgActive[c] && rawOf(c) < 0;
            b[2*c+1] = cfgActive[c] && rawOf(c) > 65535;
        end
        return b;
    endfunction

    task automatic randomCmd();
        for (int c = 0; c < 8; c++)
        begin
            lfsr = lfsrNext(lfsr);
            cmdWords[c] = lfsr;
        end
    endtask

    // stale alarms are cleared before the alarm bytes are compared
    task automatic sendAndCheck();
        pulse(cmdReq, 1);
        for (int c = 0; c < 8; c++)
            check(32'(dacCode[c]), 32'(expCode(c)));
        clear(16'h00FF);
        check(diagWord, {8'h00, rangeBits(), 8'h00});
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {cmdReq, clrReq, resetReq, scanEnable, cfgLoad, backplaneLost, watchdogExpired} = '0;
        {calFault, openWireSense, cmdWords, clrWord, cfgTimeoutMs} = '0;
        cfgActive = 8'hFF;
        cfgHoldLast = 1'b1;
        cfgDiagBytes = 3'h4;
        userPowerOk = 1'b1;
        lfsr = 16'hE6BE;
        for (int c = 0; c < 8; c++)
        begin
            cfgRange[c] = 2'(c % 4);
            cfgPoints[c] = coc_pkg::POINTS_RST;
        end
        // custom points: rising slope, and a falling one
        cfgPoints[0] = '{16'hFC18, 16'h03E8, 16'h0000, 16'h4E20};
        cfgPoints[4] = '{16'h03E8, 16'hFC18, 16'h0000, 16'h4E20};
        resetn = 1'b0;
        tick(10);
        resetn = 1'b1;
        tick(4);
        check({link.cfgActive, link.cfgHoldLast, link.cfgDiagBytes, link.cfgTimeoutMs},
            32'h0FF401F4);
        check(32'(link.cfgRange), 32'h00005555);
        check(32'(diagWord[7]), 32'h00000001);
        clear(16'h0100);
        check(32'(diagWord[7]), 32'h00000000);
        pulse(cfgLoad, 1);
        for (int i = 0; i < 40; i++)
        begin
            randomCmd();
            for (int c = 0; c < 8 && i < 6; c++)
                cmdWords[c] = CORNER[(i + c) % 6];
            sendAndCheck();
        end
        // deactivate a channel that holds an alarm
        cmdWords = {8{16'h7FFF}};
        pulse(cmdReq, 1);
        cfgActive = 8'hFE;
        pulse(cfgLoad, 1);
        check(32'(diagWord[9]), 32'h00000001);
        clear(16'h0001);
        check(32'(diagWord[9:8]), 32'h0);
        sendAndCheck();
        cfgActive = 8'hFF;
        pulse(cfgLoad, 1);
        // hold on module reset, backplane loss, watchdog
        for (int k = 0; k < 3; k++)
        begin
            randomCmd();
            sendAndCheck();
            if (k == 0)
                pulse(resetReq, 1);
            else if (k == 1)
                pulse(backplaneLost, 4);
            else
                pulse(watchdogExpired, 4);
            for (int c = 0; c < 8; c++)
                check(32'(dacCode[c]), 32'(expCode(c) & (k == 0 ? 16'hFFFF : 16'hFFFC)));
        end
        userPowerOk = 1'b0;
        tick(8);
        check(32'(|dacCode), 32'h0);
        check(32'(diagWord[7]), 32'h00000001);
        userPowerOk = 1'b1;
        tick(4);
        clear(16'h0100);
        check({30'h0, |dacCode, diagWord[7]}, 32'h0);
        sendAndCheck();
        cfgHoldLast = 1'b0;
        pulse(cfgLoad, 1);
        sendAndCheck();
        pulse(resetReq, 1);
        check(32'(|dacCode), 32'h0);
        // output timeout of 2 ms, 20 cycles here
        scanEnable = 1'b1;
        cfgTimeoutMs = 16'h0002;
        pulse(cfgLoad, 1);
        randomCmd();
        pulse(cmdReq, 1);
        tick(30);
        check(32'(|dacCode), 32'h0);
        check(32'(diagWord[3]), 32'h00000001);
        scanEnable = 1'b0;
        cfgTimeoutMs = 16'h0000;
        pulse(cfgLoad, 1);
        clear(16'h0200);
        check(32'(diagWord[3]), 32'h00000000);
        // open wire needs a current at or above threshold, then length cuts
        cmdWords = {8{16'h4E20}};
        openWireSense = 8'hFF;
        pulse(cmdReq, 1);
        check(32'(diagWord[31:24]), 32'h000000EF);
        cfgDiagBytes = 3'h2;
        pulse(cfgLoad, 1);
        check(32'(diagWord[31:16]), 32'h0);
        cfgDiagBytes = 3'h0;
        pulse(cfgLoad, 1);
        check(diagWord, 32'h0);
        openWireSense = 8'h00;
        cfgDiagBytes = 3'h4;
        pulse(cfgLoad, 1);
        clear(16'h00FF);
        check(32'(diagWord[31:24]), 32'h00000000);
        // calibration bits survive a full clear
        calFault = 5'h1F;
        tick(6);
        calFault = 5'h00;
        clear(16'hFFFF);
        check(32'(diagWord[7:0]), 32'h00000057);
        giveVerdict();
    end

    // hang guard, well past the run's length
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errCount++;
        giveVerdict();
    end
endmodule // current_output_channel_control_bench
